// >>> common/lnbc_pkg.sv
// types shared by the regulator control logic
package lnbc_pkg;
  typedef enum logic [1:0] {
    LNBC_V13 = 2'b00,
    LNBC_V14 = 2'b01,
    LNBC_V18 = 2'b10,
    LNBC_V19 = 2'b11
  } lnbc_vsel_t;

  typedef enum logic [1:0] {
    LNBC_OL_IDLE = 2'b00,
    LNBC_OL_WAIT = 2'b01,
    LNBC_OL_OFF  = 2'b10,
    LNBC_OL_ON   = 2'b11
  } lnbc_ol_state_t;

  typedef struct packed {
    logic       overload;
    logic       clamp;
    logic       back_cur;
    logic       over_temp_hi;
    logic       cooled_lo;
    logic       supply_ok;
  } lnbc_sense_t;

  typedef struct packed {
    logic       boost_en;
    logic       linear_en;
    logic       current_clamp;
    lnbc_vsel_t vsel;
    logic [1:0] ilim_sel;
    logic       tone;
  } lnbc_drive_t;
endpackage

// >>> common/lnbc_regs.svh
// register offsets, field positions, reset values and timing figures for the regulator control logic
`ifndef LNBC_REGS_SVH
`define LNBC_REGS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LNBC_OFS_STATUS   12'h000
`define LNBC_OFS_TONE     12'h004
`define LNBC_OFS_COMMAND  12'h008
`define LNBC_OFS_CONTROL  12'h00C
`define LNBC_OFS_EVENTS   12'h010
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LNBC_ST_BCF       0
`define LNBC_ST_OLF       1
`define LNBC_ST_UVF       2
`define LNBC_ST_OTF       4
`define LNBC_TN_TTH       5
`define LNBC_TN_TONE_PASSTHROUGH_SELECT      6
`define LNBC_TN_ENT       7
`define LNBC_CM_ISL       0
`define LNBC_CM_ISH       1
`define LNBC_CM_VSP       3
`define LNBC_CM_DCL       4
`define LNBC_CT_LOW_RANGE_FINE_BIT      0
`define LNBC_CT_HIGH_RANGE_FINE_BIT      1
`define LNBC_CT_EN        4
`define LNBC_RST_VAL      8'h00
// ------------------------------------------------------------
// timing figures
// ------------------------------------------------------------
`define LNBC_CLK_MHZ      250
`define LNBC_TONE_HZ      22000
`define LNBC_OSC_MULT     20
`define LNBC_DLY_NS       23000
`define LNBC_TOFF_MS      900
`define LNBC_TON_MS       20
`define LNBC_BC_SENSE_US  100
`define LNBC_BC_OFF_MS    5
`define LNBC_SOFT_US      1000
`define LNBC_DLY_CYC      ((`LNBC_DLY_NS * `LNBC_CLK_MHZ + 999) / 1000)
`define LNBC_TOFF_CYC     (`LNBC_TOFF_MS * 1000 * `LNBC_CLK_MHZ)
`define LNBC_TON_CYC      (`LNBC_TON_MS * 1000 * `LNBC_CLK_MHZ)
`define LNBC_BCS_CYC      (`LNBC_BC_SENSE_US * `LNBC_CLK_MHZ)
`define LNBC_BCO_CYC      (`LNBC_BC_OFF_MS * 1000 * `LNBC_CLK_MHZ)
`define LNBC_SOFT_CYC     (`LNBC_SOFT_US * `LNBC_CLK_MHZ)
`define LNBC_OSC_HALF     (`LNBC_CLK_MHZ * 1000000 / (2 * `LNBC_TONE_HZ * `LNBC_OSC_MULT))
`endif

// >>> hw/lnbc_core.sv
// control logic of a single-output antenna supply regulator with an APB register slave
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "lnbc_regs.svh"

module lnbc_core #(
  parameter int unsigned DLY_CYC  = `LNBC_DLY_CYC,
  parameter int unsigned TOFF_CYC = `LNBC_TOFF_CYC,
  parameter int unsigned TON_CYC  = `LNBC_TON_CYC,
  parameter int unsigned BCS_CYC  = `LNBC_BCS_CYC,
  parameter int unsigned BCO_CYC  = `LNBC_BCO_CYC,
  parameter int unsigned SOFT_CYC = `LNBC_SOFT_CYC,
  parameter int unsigned OSC_HALF = `LNBC_OSC_HALF
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [11:0]          paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire logic                 ext_modulation_pin_in,
  input  wire logic                 transmit_indicate_pin_in,
  input  wire logic                 range_select_pin_in,
  input  wire logic                 tone_detector_input_in,
  input  wire logic                 bus_reset_in,
  input  wire lnbc_pkg::lnbc_sense_t sense_in,
  output lnbc_pkg::lnbc_drive_t     drive_out,
  output logic                      converter_clk_out,
  output logic                      detect_thresh_hi_out,
  output logic                      tone_detected_out,
  output logic                      tone_detected_oe_n_out,
  output logic                      fault_out,
  output logic                      fault_oe_n_out
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_m_q;
  logic [NSYNC-1:0] pin_s_q;
  assign pin_raw = {ext_modulation_pin_in, transmit_indicate_pin_in, range_select_pin_in,
                    tone_detector_input_in, bus_reset_in, sense_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk_in)
      begin
        if (!rst_n_in)
        begin
          pin_m_q[gi] <= 1'b0;
          pin_s_q[gi] <= 1'b0;
        end
        else
        begin
          pin_m_q[gi] <= pin_raw[gi];
          pin_s_q[gi] <= pin_m_q[gi];
        end
      end
    end
  endgenerate

  logic                  ext_modulation_pin_s;
  logic                  txt_s;
  logic                  rsel_s;
  logic                  tone_detector_input_s;
  logic                  busrst_s;
  lnbc_pkg::lnbc_sense_t sense_s;
  assign {ext_modulation_pin_s, txt_s, rsel_s, tone_detector_input_s, busrst_s, sense_s} = pin_s_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] tone_reg_q;
  logic [7:0] cmd_reg_q;
  logic [7:0] ctl_reg_q;
  logic       otf_q;
  logic       olf_q;
  logic       bcf_q;
  logic       soft_done_q;
  logic       wr_acc;
  logic       otf_rise;
  assign wr_acc   = psel_in && penable_in && pwrite_in;
  assign otf_rise = sense_s.over_temp_hi && !otf_q;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || !sense_s.supply_ok)
    begin
      tone_reg_q <= `LNBC_RST_VAL;
      cmd_reg_q  <= `LNBC_RST_VAL;
      ctl_reg_q  <= `LNBC_RST_VAL;
    end
    else if (otf_rise)
    begin
      tone_reg_q <= `LNBC_RST_VAL;
      cmd_reg_q  <= `LNBC_RST_VAL;
      ctl_reg_q  <= `LNBC_RST_VAL;
    end
    else if (wr_acc)
    begin
      if (paddr_in == `LNBC_OFS_TONE)
        tone_reg_q <= pwdata_in[7:0];
      if (paddr_in == `LNBC_OFS_COMMAND)
        cmd_reg_q <= pwdata_in[7:0];
      if (paddr_in == `LNBC_OFS_CONTROL)
        ctl_reg_q <= pwdata_in[7:0];
    end
  end

  logic tone_on_bit;
  logic tone_passthrough_select;
  logic static_limit_bit;
  logic pin_override_disable;
  logic en;
  assign tone_on_bit   = tone_reg_q[`LNBC_TN_ENT];
  assign tone_passthrough_select  = tone_reg_q[`LNBC_TN_TONE_PASSTHROUGH_SELECT];
  assign static_limit_bit   = cmd_reg_q[`LNBC_CM_DCL];
  assign pin_override_disable = cmd_reg_q[`LNBC_CM_VSP];
  assign en    = ctl_reg_q[`LNBC_CT_EN];

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  logic [7:0] status_v;
  always_comb
  begin
    status_v = 8'h00;
    status_v[`LNBC_ST_BCF] = bcf_q;
    status_v[`LNBC_ST_OLF] = olf_q;
    status_v[`LNBC_ST_UVF] = !sense_s.supply_ok;
    status_v[`LNBC_ST_OTF] = otf_q;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      if (psel_in && !penable_in)
      begin
        case (paddr_in)
          `LNBC_OFS_STATUS:  prdata_out <= {24'h00_0000, status_v};
          `LNBC_OFS_TONE:    prdata_out <= {24'h00_0000, tone_reg_q};
          `LNBC_OFS_COMMAND: prdata_out <= {24'h00_0000, cmd_reg_q};
          `LNBC_OFS_CONTROL: prdata_out <= {24'h00_0000, ctl_reg_q};
          `LNBC_OFS_EVENTS:  prdata_out <= {28'h000_0000, busrst_s, soft_done_q, tone_detector_input_s, txt_s};
          default:           pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // oscillator: converter clock and tone
  // ------------------------------------------------------------
  logic [15:0] osc_cnt_q;
  logic [4:0]  osc_div_q;
  logic        conv_q;
  logic        tone_q;
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      osc_cnt_q <= 16'h0000;
      osc_div_q <= 5'h00;
      conv_q    <= 1'b0;
      tone_q    <= 1'b0;
    end
    else if (osc_cnt_q == 16'(OSC_HALF - 1))
    begin
      osc_cnt_q <= 16'h0000;
      conv_q    <= !conv_q;
      if (osc_div_q == 5'(`LNBC_OSC_MULT - 1))
      begin
        osc_div_q <= 5'h00;
        tone_q    <= !tone_q;
      end
      else
        osc_div_q <= osc_div_q + 5'h01;
    end
    else
      osc_cnt_q <= osc_cnt_q + 16'h0001;
  end

  logic tone_d;
  always_comb
  begin
    if (tone_on_bit)
      tone_d = tone_q;
    else if (tone_passthrough_select)
      tone_d = ext_modulation_pin_s;
    else
      tone_d = tone_q && ext_modulation_pin_s;
  end

  // ------------------------------------------------------------
  // soft-start and thermal
  // ------------------------------------------------------------
  logic [31:0] soft_cnt_q;
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || !sense_s.supply_ok)
    begin
      soft_cnt_q  <= 32'h0000_0000;
      soft_done_q <= 1'b0;
    end
    else if (!soft_done_q)
    begin
      soft_cnt_q  <= soft_cnt_q + 32'h0000_0001;
      soft_done_q <= (soft_cnt_q == 32'(SOFT_CYC - 1));
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      otf_q <= 1'b0;
    else if (sense_s.over_temp_hi)
      otf_q <= 1'b1;
    else if (sense_s.cooled_lo)
      otf_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // overload protection
  // ------------------------------------------------------------
  lnbc_pkg::lnbc_ol_state_t ol_q;
  logic [31:0]              ol_cnt_q;
  logic                     ol_seen_q;
  logic                     run_ok;
  assign run_ok = en && sense_s.supply_ok && !otf_q && soft_done_q;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || !run_ok || static_limit_bit)
    begin
      ol_q      <= lnbc_pkg::LNBC_OL_IDLE;
      ol_cnt_q  <= 32'h0000_0000;
      ol_seen_q <= 1'b0;
    end
    else
    begin
      ol_cnt_q <= ol_cnt_q + 32'h0000_0001;
      case (ol_q)
        lnbc_pkg::LNBC_OL_IDLE:
        begin
          ol_cnt_q <= 32'h0000_0000;
          if (sense_s.overload)
            ol_q <= lnbc_pkg::LNBC_OL_WAIT;
        end
        lnbc_pkg::LNBC_OL_WAIT:
        begin
          if (!sense_s.overload)
            ol_q <= lnbc_pkg::LNBC_OL_IDLE;
          else if (ol_cnt_q == 32'(DLY_CYC - 1))
          begin
            ol_q     <= lnbc_pkg::LNBC_OL_OFF;
            ol_cnt_q <= 32'h0000_0000;
          end
        end
        lnbc_pkg::LNBC_OL_OFF:
        begin
          if (ol_cnt_q == 32'(TOFF_CYC - 1))
          begin
            ol_q      <= lnbc_pkg::LNBC_OL_ON;
            ol_cnt_q  <= 32'h0000_0000;
            ol_seen_q <= 1'b0;
          end
        end
        lnbc_pkg::LNBC_OL_ON:
        begin
          if (sense_s.overload)
            ol_seen_q <= 1'b1;
          if (ol_cnt_q == 32'(TON_CYC - 1))
          begin
            ol_cnt_q <= 32'h0000_0000;
            if (ol_seen_q || sense_s.overload)
              ol_q <= lnbc_pkg::LNBC_OL_OFF;
            else
              ol_q <= lnbc_pkg::LNBC_OL_IDLE;
          end
        end
        default: ol_q <= lnbc_pkg::LNBC_OL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || !soft_done_q)
      olf_q <= 1'b0;
    else if (static_limit_bit)
      olf_q <= sense_s.clamp;
    else if (ol_q == lnbc_pkg::LNBC_OL_WAIT && ol_cnt_q == 32'(DLY_CYC - 1) && sense_s.overload)
      olf_q <= 1'b1;
    else if (ol_q == lnbc_pkg::LNBC_OL_IDLE)
      olf_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // back-current cycling
  // ------------------------------------------------------------
  logic [31:0] bc_cnt_q;
  logic        bc_off_q;
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || !run_ok)
    begin
      bc_cnt_q <= 32'h0000_0000;
      bc_off_q <= 1'b0;
    end
    else if (bc_off_q)
    begin
      bc_cnt_q <= bc_cnt_q + 32'h0000_0001;
      if (bc_cnt_q == 32'(BCO_CYC - 1))
      begin
        bc_off_q <= 1'b0;
        bc_cnt_q <= 32'h0000_0000;
      end
    end
    else if (!sense_s.back_cur)
      bc_cnt_q <= 32'h0000_0000;
    else if (bc_cnt_q == 32'(BCS_CYC - 1))
    begin
      bc_off_q <= 1'b1;
      bc_cnt_q <= 32'h0000_0000;
    end
    else
      bc_cnt_q <= bc_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || !soft_done_q)
      bcf_q <= 1'b0;
    else if (bc_off_q)
      bcf_q <= 1'b1;
    else if (!sense_s.back_cur && bc_cnt_q == 32'h0000_0000)
      bcf_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic power_on;
  logic rng_hi;
  logic fine;
  assign power_on = run_ok && !bc_off_q && (ol_q != lnbc_pkg::LNBC_OL_OFF);
  assign rng_hi   = pin_override_disable ? ctl_reg_q[`LNBC_CT_HIGH_RANGE_FINE_BIT] : rsel_s;
  // register mode takes the low bit as the fine step; pin mode takes the fine bit of the chosen band
  assign fine     = (rng_hi && !pin_override_disable) ? ctl_reg_q[`LNBC_CT_HIGH_RANGE_FINE_BIT] : ctl_reg_q[`LNBC_CT_LOW_RANGE_FINE_BIT];

  logic fault_d;
  assign fault_d = otf_q || olf_q || bcf_q || !sense_s.supply_ok || busrst_s;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      drive_out              <= '0;
      converter_clk_out      <= 1'b0;
      detect_thresh_hi_out   <= 1'b0;
      tone_detected_out      <= 1'b0;
      tone_detected_oe_n_out <= 1'b1;
      fault_out              <= 1'b0;
      fault_oe_n_out         <= 1'b1;
    end
    else
    begin
      drive_out.boost_en      <= power_on;
      drive_out.linear_en     <= power_on;
      drive_out.current_clamp <= static_limit_bit || (ol_q == lnbc_pkg::LNBC_OL_ON);
      drive_out.vsel          <= lnbc_pkg::lnbc_vsel_t'({rng_hi, fine});
      drive_out.ilim_sel      <= {cmd_reg_q[`LNBC_CM_ISH], cmd_reg_q[`LNBC_CM_ISL]};
      drive_out.tone          <= power_on && tone_d;
      converter_clk_out       <= sense_s.supply_ok && conv_q;
      detect_thresh_hi_out    <= txt_s;
      tone_detected_out       <= 1'b0;
      tone_detected_oe_n_out  <= !tone_detector_input_s;
      fault_out               <= 1'b0;
      fault_oe_n_out          <= !fault_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_shutdown_boost: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !en |=> !drive_out.boost_en) else $error("boost on while disabled");
  a_otf_clears_regs: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    otf_rise |=> ctl_reg_q == 8'h00 && cmd_reg_q == 8'h00) else $error("regs kept on overtemp");
  a_ol_flag_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(ol_q == lnbc_pkg::LNBC_OL_OFF) |-> olf_q) else $error("overload flag missing");
  a_static_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    static_limit_bit && soft_done_q && $past(static_limit_bit) && $past(soft_done_q) |->
    olf_q == $past(sense_s.clamp)) else $error("static flag wrong");
  a_tone_cont: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tone_on_bit && power_on |=> drive_out.tone == $past(tone_q)) else $error("tone not continuous");
  a_tone_pass: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !tone_on_bit && tone_passthrough_select && power_on |=> drive_out.tone == $past(ext_modulation_pin_s)) else $error("passthrough wrong");
  a_tone_gate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !tone_on_bit && !tone_passthrough_select && !ext_modulation_pin_s |=> !drive_out.tone) else $error("tone not gated");
  a_tone_detected_out_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tone_detector_input_s |=> !tone_detected_oe_n_out) else $error("detect pin released");
  a_fault_pin: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    otf_q |=> !fault_oe_n_out) else $error("fault pin released");
  a_bc_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    bc_off_q |=> !drive_out.boost_en) else $error("output on in back off");
  a_volt_reg: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    pin_override_disable |=> drive_out.vsel == $past(ctl_reg_q[1:0])) else $error("voltage bits wrong");
  c_ol_cycle: cover property (@(posedge mclk_in) ol_q == lnbc_pkg::LNBC_OL_ON && sense_s.overload);
  c_ol_recover: cover property (@(posedge mclk_in) $fell(olf_q));
  c_bc_cycle: cover property (@(posedge mclk_in) $rose(bc_off_q));
  c_otf_event: cover property (@(posedge mclk_in) otf_rise);
endmodule // lnbc_core

// >>> sim/lnbc_plant.sv
// load and supply model feeding the sense inputs of the regulator control logic
`timescale 1ns/1ps
module lnbc_plant (
  input  wire logic                  short_in,
  input  wire logic                  backfeed_in,
  input  wire logic                  hot_in,
  input  wire logic                  uv_in,
  input  wire lnbc_pkg::lnbc_drive_t drive_in,
  output lnbc_pkg::lnbc_sense_t      sense_out
);
  always_comb
  begin
    // a shorted load draws current only while the output is driven
    sense_out.overload     = short_in & drive_in.boost_en;
    sense_out.clamp        = short_in & drive_in.boost_en;
    sense_out.back_cur     = backfeed_in;
    sense_out.over_temp_hi = hot_in;
    sense_out.cooled_lo    = ~hot_in;
    sense_out.supply_ok    = ~uv_in;
  end
endmodule // lnbc_plant

// >>> sim/tb_top.sv
// self-checking bench for the regulator control logic
`timescale 1ns/1ps
`include "lnbc_regs.svh"
module tb_top;
  logic                  clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, r;
  logic                  ext_mod, txi, rsel, tone_detector_input, short_f, back_f, hot_f, uv_f, busrst;
  lnbc_pkg::lnbc_sense_t sense;
  lnbc_pkg::lnbc_drive_t drive;
  logic                  conv_clk, thr_hi, td, td_oe_n, flt, flt_oe_n;
  int                    bad_count, checks_done, n;

  // shortened timing so that every protection cycle fits in the run
  localparam int unsigned TB_DLY  = 4;
  localparam int unsigned TB_TOFF = 40;
  localparam int unsigned TB_TON  = 20;
  localparam int unsigned TB_BCS  = 10;
  localparam int unsigned TB_BCO  = 30;
  localparam int unsigned TB_SOFT = 8;
  localparam int unsigned TB_OSC  = 2;

  lnbc_core #(.DLY_CYC(TB_DLY), .TOFF_CYC(TB_TOFF), .TON_CYC(TB_TON), .BCS_CYC(TB_BCS), .BCO_CYC(TB_BCO),
    .SOFT_CYC(TB_SOFT), .OSC_HALF(TB_OSC))
  i_lnbc_core (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ext_modulation_pin_in(ext_mod), .transmit_indicate_pin_in(txi), .range_select_pin_in(rsel),
    .tone_detector_input_in(tone_detector_input), .bus_reset_in(busrst), .sense_in(sense), .drive_out(drive),
    .converter_clk_out(conv_clk), .detect_thresh_hi_out(thr_hi), .tone_detected_out(td),
    .tone_detected_oe_n_out(td_oe_n), .fault_out(flt), .fault_oe_n_out(flt_oe_n));

  lnbc_plant i_lnbc_plant (.short_in(short_f), .backfeed_in(back_f), .hot_in(hot_f), .uv_in(uv_f),
    .drive_in(drive), .sense_out(sense));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  // setup cycle, then access held until pready is seen at a rising edge; one idle edge follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
    chk(e, experr);
  endtask

  task automatic wait_boost(input logic v, input int lim);
    n = 0;
    while (drive.boost_en !== v && n < lim) begin @(posedge clk); n++; end
    chk(n < lim, 1'b1);
  endtask

  // counts rising edges of tone (sel 0) or converter clock (sel 1) over c intervals
  task automatic rises(input int sel, input int c, output int cnt);
    logic p, q;
    cnt = 0;
    p = sel ? conv_clk : drive.tone;
    repeat (c)
    begin
      @(posedge clk);
      q = sel ? conv_clk : drive.tone;
      if (q === 1'b1 && p === 1'b0) cnt++;
      p = q;
    end
  endtask

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #(4 * 60000);
    bad_count++;
    finish_test;
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_mod, txi, rsel, tone_detector_input, short_f, back_f, hot_f, uv_f, busrst} = '0;
    bad_count = 0;
    checks_done = 0;
    tick(16);
    rst_n <= 1'b1;
    tick(20);
    rd(`LNBC_OFS_STATUS, 32'h0000_0000, 1'b0);
    rd(`LNBC_OFS_TONE, 32'h0000_0000, 1'b0);
    rd(`LNBC_OFS_COMMAND, 32'h0000_0000, 1'b0);
    rd(`LNBC_OFS_CONTROL, 32'h0000_0000, 1'b0);
    chk(drive.boost_en, 1'b0);
    chk(drive.linear_en, 1'b0);
    chk({flt, flt_oe_n}, 2'b01);
    rd(12'h020, 32'h0000_0000, 1'b1);
    wr(`LNBC_OFS_STATUS, 32'h0000_00FF);
    rd(`LNBC_OFS_STATUS, 32'h0000_0000, 1'b0);
    rises(1, 40, n);
    chk(n, 40 / (2 * TB_OSC));
    // voltage selection from register bits alone, then current-limit bits, then voltage selection with the range pin
    wr(`LNBC_OFS_COMMAND, 32'h0000_0008);
    for (int i = 0; i < 4; i++)
    begin
      wr(`LNBC_OFS_CONTROL, 32'h0000_0010 | i);
      tick(4);
      chk(drive.boost_en, 1'b1);
      chk(drive.vsel, i[1:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`LNBC_OFS_COMMAND, i);
      tick(4);
      chk(drive.ilim_sel, i[1:0]);
    end
    for (int i = 0; i < 8; i++)
    begin
      rsel <= i[2];
      wr(`LNBC_OFS_CONTROL, 32'h0000_0010 | i[1:0]);
      tick(6);
      chk(drive.vsel, {i[2], i[2] ? i[1] : i[0]});
    end
    // tone sources; the tone-on bit stays clear while the pin carries messages
    wr(`LNBC_OFS_TONE, 32'h0000_0000);
    rises(0, 12000, n);
    chk(n, 0);
    ext_mod <= 1'b1;
    rises(0, 12000, n);
    chk(n > 0, 1'b1);
    wr(`LNBC_OFS_TONE, 32'h0000_0040);
    tick(6);
    chk(drive.tone, 1'b1);
    ext_mod <= 1'b0;
    tick(6);
    chk(drive.tone, 1'b0);
    wr(`LNBC_OFS_TONE, 32'h0000_0080);
    tick(4);
    rises(0, 12000, n);
    chk(n, 12000 / (2 * TB_OSC * `LNBC_OSC_MULT));
    // detector threshold and tone-detect output
    txi <= 1'b1;
    tone_detector_input <= 1'b1;
    tick(6);
    chk(thr_hi, 1'b1);
    chk({td, td_oe_n}, 2'b00);
    rd(`LNBC_OFS_EVENTS, 32'h0000_0007, 1'b0);
    txi <= 1'b0;
    tone_detector_input <= 1'b0;
    tick(6);
    chk({thr_hi, td_oe_n}, 2'b01);
    // bus reset pin pulls the fault output low while it stands
    busrst <= 1'b1;
    tick(6);
    chk({flt, flt_oe_n}, 2'b00);
    rd(`LNBC_OFS_EVENTS, 32'h0000_000C, 1'b0);
    busrst <= 1'b0;
    tick(6);
    chk(flt_oe_n, 1'b1);
    // start in static limiting, then go dynamic
    wr(`LNBC_OFS_COMMAND, 32'h0000_0018);
    short_f <= 1'b1;
    tick(8);
    rd(`LNBC_OFS_STATUS, 32'h0000_0002, 1'b0);
    chk(drive.boost_en, 1'b1);
    chk({drive.linear_en, drive.current_clamp}, 2'b11);
    short_f <= 1'b0;
    tick(8);
    rd(`LNBC_OFS_STATUS, 32'h0000_0000, 1'b0);
    wr(`LNBC_OFS_COMMAND, 32'h0000_0008);
    short_f <= 1'b1;
    wait_boost(1'b0, 20);
    chk(n >= TB_DLY, 1'b1);
    rd(`LNBC_OFS_STATUS, 32'h0000_0002, 1'b0);
    chk(flt_oe_n, 1'b0);
    wait_boost(1'b1, 60);
    chk(n >= TB_TOFF - 6 && n <= TB_TOFF + 4, 1'b1);
    chk(drive.current_clamp, 1'b1);
    wait_boost(1'b0, 30);
    short_f <= 1'b0;
    wait_boost(1'b1, 60);
    tick(30);
    rd(`LNBC_OFS_STATUS, 32'h0000_0000, 1'b0);
    chk(drive.boost_en, 1'b1);
    chk({drive.linear_en, drive.current_clamp}, 2'b10);
    // back current
    back_f <= 1'b1;
    wait_boost(1'b0, 20);
    rd(`LNBC_OFS_STATUS, 32'h0000_0001, 1'b0);
    wait_boost(1'b1, 40);
    wait_boost(1'b0, 20);
    back_f <= 1'b0;
    wait_boost(1'b1, 60);
    tick(30);
    rd(`LNBC_OFS_STATUS, 32'h0000_0000, 1'b0);
    // over temperature clears the host registers
    wr(`LNBC_OFS_TONE, 32'h0000_0020);
    hot_f <= 1'b1;
    wait_boost(1'b0, 20);
    chk(flt_oe_n, 1'b0);
    rd(`LNBC_OFS_STATUS, 32'h0000_0010, 1'b0);
    rd(`LNBC_OFS_CONTROL, 32'h0000_0000, 1'b0);
    rd(`LNBC_OFS_TONE, 32'h0000_0000, 1'b0);
    hot_f <= 1'b0;
    tick(10);
    rd(`LNBC_OFS_STATUS, 32'h0000_0000, 1'b0);
    wr(`LNBC_OFS_CONTROL, 32'h0000_0010);
    wait_boost(1'b1, 30);
    chk(flt_oe_n, 1'b1);
    // undervoltage
    uv_f <= 1'b1;
    wait_boost(1'b0, 20);
    chk(flt_oe_n, 1'b0);
    uv_f <= 1'b0;
    tick(30);
    chk(flt_oe_n, 1'b1);
    rd(`LNBC_OFS_CONTROL, 32'h0000_0000, 1'b0);
    finish_test;
  end
endmodule // tb_top
